// ===== verilog/spb_top.sv
// Serial port of the radio module with receive and transmit byte buffers
// How it works
// - Frame: low start, 8 bits LSB first, high stop
// - Both ends match settings; parity checked inbound
// - Each byte received without frame or parity error waits in receive buffer if room
// - No draining while radio reception continues
// - Discovery, retries, broadcasts also stall draining
// - Radio payload goes to transmit buffer, out
// - Packet too big for free space: drop whole
// - CTS high within 17 of full, low at 34 free
// - RTS high holds transmit output
`include "spb_defs.svh"
`default_nettype none
module spb_top (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // Configuration straps
  input wire logic parity_en,
  input wire logic parity_odd,
  input wire logic cts_flow_en,
  input wire logic rts_flow_en,
  // Host serial pins
  input wire logic din,
  output logic dout,
  output logic cts_n,
  input wire logic rts_n,
  // Radio activity that holds back serial-to-radio draining
  input wire logic rf_rx_busy,
  input wire logic rf_tx_busy,
  // Serial-to-radio byte stream
  output logic rad_tx_valid,
  input wire logic rad_tx_ready,
  output logic [7:0] rad_tx_data,
  // Radio-to-serial packet bytes
  input wire logic rf_in_valid,
  input wire logic rf_in_first,
  input wire logic [7:0] rf_in_len,
  input wire logic [7:0] rf_in_data,
  // Events
  output logic pkt_dropped,
  output logic frame_err,
  output logic parity_err,
  output logic rx_overrun
);
  localparam logic [15:0] TICK_LAST = 16'(`SPB_TICK_DIV - 1);

  // ----------------------------------------
  // Oversample tick and pin synchronisers
  // ----------------------------------------
  logic [15:0] div_cnt; // Counts ref_clk cycles per sixteenth of a bit
  logic [15:0] next_div_cnt;
  logic tick;
  logic din_s1, din_s2, rts_s1, rts_s2; // Two-flop synchronisers, idle high
  assign tick = (div_cnt == TICK_LAST);

  // Divider wraps once per oversample period
  always_comb begin
    next_div_cnt = tick ? 16'h0000 : div_cnt + 16'h0001;
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      div_cnt <= 16'h0000;
      din_s1 <= 1'b1;
      din_s2 <= 1'b1;
      rts_s1 <= 1'b1;
      rts_s2 <= 1'b1;
    end else begin
      div_cnt <= next_div_cnt;
      din_s1 <= din;
      din_s2 <= din_s1;
      rts_s1 <= rts_n;
      rts_s2 <= rts_s1;
    end
  end

  // ----------------------------------------
  // Serial receiver
  // ----------------------------------------
  spb_pkg::spb_ser_t rx_st, next_rx_st;
  logic [3:0] rx_cnt, next_rx_cnt; // Sixteenths within the current bit
  logic [2:0] rx_bit, next_rx_bit; // Data bit index
  logic [7:0] rx_sh, next_rx_sh; // Shift register, filled from the top
  logic rx_perr, next_rx_perr; // Parity mismatch of this byte
  logic rx_push, next_rx_push; // One-cycle good-byte strobe
  logic next_frame_err, next_parity_err;

  // Frames are sampled mid-bit; a false start shorter than half a bit is ignored
  always_comb begin
    next_rx_st = rx_st;
    next_rx_cnt = rx_cnt;
    next_rx_bit = rx_bit;
    next_rx_sh = rx_sh;
    next_rx_perr = rx_perr;
    next_rx_push = 1'b0;
    next_frame_err = 1'b0;
    next_parity_err = 1'b0;
    if (tick) begin
      next_rx_cnt = rx_cnt + 4'h1;
      case (rx_st)
        spb_pkg::spb_idle: begin
          // Line idles high; low begins a frame
          next_rx_cnt = 4'h0;
          next_rx_perr = 1'b0;
          if (!din_s2) begin
            next_rx_st = spb_pkg::spb_start;
          end
        end
        spb_pkg::spb_start: begin
          if (rx_cnt == `SPB_MID_TICK) begin
            next_rx_cnt = 4'h0;
            next_rx_bit = 3'h0;
            next_rx_st = din_s2 ? spb_pkg::spb_idle : spb_pkg::spb_data;
          end
        end
        spb_pkg::spb_data: begin
          if (rx_cnt == `SPB_LAST_TICK) begin
            next_rx_sh = {din_s2, rx_sh[7:1]};
            next_rx_bit = rx_bit + 3'h1;
            if (rx_bit == `SPB_LAST_BIT) begin
              next_rx_st = parity_en ? spb_pkg::spb_par : spb_pkg::spb_stop;
            end
          end
        end
        spb_pkg::spb_par: begin
          if (rx_cnt == `SPB_LAST_TICK) begin
            next_rx_perr = din_s2 ^ (^rx_sh) ^ parity_odd;
            next_rx_st = spb_pkg::spb_stop;
          end
        end
        spb_pkg::spb_stop: begin
          if (rx_cnt == `SPB_LAST_TICK) begin
            next_rx_st = spb_pkg::spb_idle;
            next_frame_err = !din_s2;
            next_parity_err = din_s2 & rx_perr;
            next_rx_push = din_s2 & !rx_perr;
          end
        end
        default: begin
          next_rx_st = spb_pkg::spb_idle;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_st <= spb_pkg::spb_idle;
      rx_cnt <= 4'h0;
      rx_bit <= 3'h0;
      rx_sh <= 8'h00;
      rx_perr <= 1'b0;
      rx_push <= 1'b0;
      frame_err <= 1'b0;
      parity_err <= 1'b0;
    end else begin
      rx_st <= next_rx_st;
      rx_cnt <= next_rx_cnt;
      rx_bit <= next_rx_bit;
      rx_sh <= next_rx_sh;
      rx_perr <= next_rx_perr;
      rx_push <= next_rx_push;
      frame_err <= next_frame_err;
      parity_err <= next_parity_err;
    end
  end

  // ----------------------------------------
  // Serial receive buffer and clear-to-send
  // ----------------------------------------
  logic [7:0] rxb_mem [0:127]; // Bytes waiting for the radio
  logic [7:0] rxb_wp, rxb_rp, next_rxb_wp, next_rxb_rp; // One extra wrap bit
  logic [7:0] rxb_used, rxb_free;
  logic rxb_push, rxb_pop, stall, skid_in_ready;
  logic next_cts_n, next_rx_overrun;
  assign rxb_used = rxb_wp - rxb_rp;
  assign rxb_free = `SPB_DEPTH - rxb_used;
  assign rxb_push = rx_push & (rxb_free != 8'h00);
  assign stall = rf_rx_busy | rf_tx_busy;
  assign rxb_pop = (rxb_used != 8'h00) & !stall & skid_in_ready;

  // Pointers and CTS hysteresis; CTS high means stop sending
  always_comb begin
    next_rxb_wp = rxb_push ? rxb_wp + 8'h01 : rxb_wp;
    next_rxb_rp = rxb_pop ? rxb_rp + 8'h01 : rxb_rp;
    next_rx_overrun = rx_push & !rxb_push;
    next_cts_n = cts_n;
    if (!cts_flow_en) begin
      next_cts_n = 1'b0;
    end else if (rxb_free <= `SPB_CTS_STOP_GAP) begin
      next_cts_n = 1'b1;
    end else if (rxb_free >= `SPB_CTS_GO_FREE) begin
      next_cts_n = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rxb_wp <= 8'h00;
      rxb_rp <= 8'h00;
      cts_n <= 1'b0;
      rx_overrun <= 1'b0;
    end else begin
      rxb_wp <= next_rxb_wp;
      rxb_rp <= next_rxb_rp;
      cts_n <= next_cts_n;
      rx_overrun <= next_rx_overrun;
    end
  end

  // Storage has no reset; pointers alone say what is valid
  always_ff @(posedge ref_clk) begin
    if (rxb_push) begin
      rxb_mem[rxb_wp[6:0]] <= rx_sh;
    end
  end

  // Two-entry stage toward the radio; radio stall also gates its output
  logic skid_valid, skid_ready;
  spb_skid u_skid (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .in_valid(rxb_pop),
    .in_data(rxb_mem[rxb_rp[6:0]]),
    .in_ready(skid_in_ready),
    .out_valid(skid_valid),
    .out_ready(skid_ready),
    .out_data(rad_tx_data)
  );
  assign rad_tx_valid = skid_valid & !stall;
  assign skid_ready = rad_tx_ready & !stall;

  // ----------------------------------------
  // Serial transmit buffer with whole-packet admission
  // ----------------------------------------
  logic [7:0] txb_mem [0:127]; // Radio payload bytes for the host
  logic [7:0] txb_wp, txb_rp, next_txb_wp, next_txb_rp;
  logic [7:0] txb_free;
  logic keep, next_keep; // Current packet was admitted
  logic fits, txb_push, txb_pop, next_pkt_dropped;
  assign txb_free = `SPB_DEPTH - (txb_wp - txb_rp);
  assign fits = (rf_in_len <= txb_free);
  assign txb_push = rf_in_valid & (rf_in_first ? fits : keep);

  // Decision is made once per packet on its first byte
  always_comb begin
    next_keep = keep;
    next_pkt_dropped = 1'b0;
    if (rf_in_valid & rf_in_first) begin
      next_keep = fits;
      next_pkt_dropped = !fits;
    end
    next_txb_wp = txb_push ? txb_wp + 8'h01 : txb_wp;
    next_txb_rp = txb_pop ? txb_rp + 8'h01 : txb_rp;
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      keep <= 1'b0;
      pkt_dropped <= 1'b0;
      txb_wp <= 8'h00;
      txb_rp <= 8'h00;
    end else begin
      keep <= next_keep;
      pkt_dropped <= next_pkt_dropped;
      txb_wp <= next_txb_wp;
      txb_rp <= next_txb_rp;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (txb_push) begin
      txb_mem[txb_wp[6:0]] <= rf_in_data;
    end
  end

  // ----------------------------------------
  // Serial transmitter
  // ----------------------------------------
  spb_pkg::spb_ser_t tx_st, next_tx_st;
  logic [3:0] tx_cnt, next_tx_cnt;
  logic [2:0] tx_bit, next_tx_bit;
  logic [7:0] tx_sh, next_tx_sh;
  logic tx_par, next_tx_par, next_dout;
  // A held-off RTS only blocks new bytes; one in flight finishes cleanly
  assign txb_pop = tick & (tx_st == spb_pkg::spb_idle) & (txb_wp != txb_rp)
                   & !(rts_flow_en & rts_s2);

  always_comb begin
    next_tx_st = tx_st;
    next_tx_cnt = tx_cnt;
    next_tx_bit = tx_bit;
    next_tx_sh = tx_sh;
    next_tx_par = tx_par;
    if (txb_pop) begin
      next_tx_sh = txb_mem[txb_rp[6:0]];
      next_tx_par = (^txb_mem[txb_rp[6:0]]) ^ parity_odd;
      next_tx_cnt = 4'h0;
      next_tx_bit = 3'h0;
      next_tx_st = spb_pkg::spb_start;
    end else if (tick & (tx_st != spb_pkg::spb_idle)) begin
      next_tx_cnt = tx_cnt + 4'h1;
      if (tx_cnt == `SPB_LAST_TICK) begin
        case (tx_st)
          spb_pkg::spb_start: begin
            next_tx_st = spb_pkg::spb_data;
          end
          spb_pkg::spb_data: begin
            next_tx_sh = {1'b0, tx_sh[7:1]};
            next_tx_bit = tx_bit + 3'h1;
            if (tx_bit == `SPB_LAST_BIT) begin
              next_tx_st = parity_en ? spb_pkg::spb_par : spb_pkg::spb_stop;
            end
          end
          spb_pkg::spb_par: begin
            next_tx_st = spb_pkg::spb_stop;
          end
          default: begin
            next_tx_st = spb_pkg::spb_idle;
          end
        endcase
      end
    end
    // Pin level follows the phase about to be entered
    case (next_tx_st)
      spb_pkg::spb_start: next_dout = 1'b0;
      spb_pkg::spb_data: next_dout = next_tx_sh[0];
      spb_pkg::spb_par: next_dout = next_tx_par;
      default: next_dout = 1'b1;
    endcase
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_st <= spb_pkg::spb_idle;
      tx_cnt <= 4'h0;
      tx_bit <= 3'h0;
      tx_sh <= 8'h00;
      tx_par <= 1'b0;
      dout <= 1'b1;
    end else begin
      tx_st <= next_tx_st;
      tx_cnt <= next_tx_cnt;
      tx_bit <= next_tx_bit;
      tx_sh <= next_tx_sh;
      tx_par <= next_tx_par;
      dout <= next_dout;
    end
  end
endmodule
`default_nettype wire

// ===== verilog/spb_defs.svh
// Constants for the serial port buffering block: timing, depths, thresholds
`ifndef SPB_DEFS_SVH
`define SPB_DEFS_SVH
// ----------------------------------------
// Timing
// ----------------------------------------
`define SPB_CLK_HZ 200000000
// Fixed host line rate; a slow rate would stretch one frame past 200k clock cycles
`define SPB_BAUD 115200
`define SPB_OVS 16
`define SPB_TICK_DIV (`SPB_CLK_HZ / (`SPB_BAUD * `SPB_OVS))
`define SPB_MID_TICK 4'h7
`define SPB_LAST_TICK 4'hF
`define SPB_LAST_BIT 3'h7
// ----------------------------------------
// Buffers and flow-control thresholds
// ----------------------------------------
`define SPB_DEPTH 8'h80
`define SPB_CTS_STOP_GAP 8'h11
`define SPB_CTS_GO_FREE 8'h22
`endif

// ===== verilog/spb_pkg.sv
// Types shared by the serial port buffering block
`default_nettype none
package spb_pkg;
  // Serial frame phases, Gray coded along idle-start-data-parity-stop
  typedef enum logic [2:0] {
    spb_idle  = 3'h0,
    spb_start = 3'h1,
    spb_data  = 3'h3,
    spb_par   = 3'h2,
    spb_stop  = 3'h6
  } spb_ser_t;
endpackage
`default_nettype wire

// ===== verilog/spb_skid.sv
// Two-entry byte buffer with valid/ready on both sides
`default_nettype none
module spb_skid (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // Filling side
  input wire logic in_valid,
  input wire logic [7:0] in_data,
  output logic in_ready,
  // Draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [7:0] out_data
);
  logic [7:0] head; // Oldest word, drives out_data straight from a flop
  logic [7:0] tail; // Second word, held while the drain stalls
  logic [1:0] fill; // Words held, 0..2
  logic [7:0] next_head;
  logic [7:0] next_tail;
  logic [1:0] next_fill;
  logic push;
  logic pop;

  // ----------------------------------------
  // Handshakes: full and empty are exact
  // ----------------------------------------
  assign in_ready = (fill != 2'h2);
  assign out_valid = (fill != 2'h0);
  assign out_data = head;
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // Next state of both entries
  always_comb begin
    next_head = head;
    next_tail = tail;
    next_fill = fill;
    case ({push, pop})
      2'b10: begin
        // Fill the first free entry
        if (fill == 2'h0) begin
          next_head = in_data;
        end else begin
          next_tail = in_data;
        end
        next_fill = fill + 2'h1;
      end
      2'b01: begin
        // Tail moves up when head leaves
        next_head = tail;
        next_fill = fill - 2'h1;
      end
      2'b11: begin
        // Pass-through when one word, rotate when two
        if (fill == 2'h1) begin
          next_head = in_data;
        end else begin
          next_head = tail;
          next_tail = in_data;
        end
      end
      default: begin
        next_fill = fill;
      end
    endcase
  end

  // Register the entries
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      head <= 8'h00;
      tail <= 8'h00;
      fill <= 2'h0;
    end else begin
      head <= next_head;
      tail <= next_tail;
      fill <= next_fill;
    end
  end
endmodule
`default_nettype wire

// ===== verif/spb_top_assertions.sv
// Port-level checker for the serial port buffering block
`include "spb_defs.svh"
`default_nettype none
module spb_chk (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // Straps and host pins
  input wire logic cts_flow_en,
  input wire logic rts_flow_en,
  input wire logic rts_n,
  input wire logic dout,
  input wire logic cts_n,
  // Radio side
  input wire logic rf_rx_busy,
  input wire logic rf_tx_busy,
  input wire logic rad_tx_valid,
  input wire logic rad_tx_ready,
  input wire logic [7:0] rad_tx_data,
  input wire logic rf_in_valid,
  input wire logic rf_in_first,
  // Events
  input wire logic pkt_dropped,
  input wire logic frame_err
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Helper counter
  // ----------------------------------------
  // One frame plus a bit: a byte in flight may finish before the hold bites
  localparam int RTS_LIM = `SPB_TICK_DIV * 16 * 11;
  int rts_cnt; // Cycles with transmit hold-off requested
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rts_cnt <= 0;
    end else if (rts_flow_en && rts_n) begin
      rts_cnt <= (rts_cnt < RTS_LIM) ? rts_cnt + 1 : rts_cnt;
    end else begin
      rts_cnt <= 0;
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  property p_rst_idle;
    $rose(arst_n) |-> dout && !cts_n && !rad_tx_valid && !pkt_dropped;
  endproperty
  property p_rx_stall;
    rf_rx_busy |-> !rad_tx_valid;
  endproperty
  property p_tx_stall;
    rf_tx_busy |-> !rad_tx_valid;
  endproperty
  property p_hold;
    rad_tx_valid && !rad_tx_ready |=> $stable(rad_tx_data) && (rad_tx_valid || rf_rx_busy || rf_tx_busy);
  endproperty
  property p_drop_cause;
    pkt_dropped |-> $past(rf_in_valid) && $past(rf_in_first);
  endproperty
  property p_start;
    $fell(dout) |=> !dout [*8];
  endproperty
  property p_rts_hold;
    rts_cnt == RTS_LIM |-> !$fell(dout);
  endproperty
  property p_cts_off;
    !cts_flow_en ##1 !cts_flow_en |-> !cts_n;
  endproperty
  property p_ferr;
    frame_err |=> !frame_err [*8];
  endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("idle levels wrong after reset");
  a_rx_stall: assert property (p_rx_stall) else $error("drained during radio receive");
  a_tx_stall: assert property (p_tx_stall) else $error("drained during radio send");
  a_hold: assert property (p_hold) else $error("buffered byte lost or changed");
  a_drop_cause: assert property (p_drop_cause) else $error("drop without packet start");
  a_start: assert property (p_start) else $error("start bit too short");
  a_rts_hold: assert property (p_rts_hold) else $error("byte started under hold-off");
  a_cts_off: assert property (p_cts_off) else $error("cts raised while disabled");
  a_ferr: assert property (p_ferr) else $error("frame error repeated");
  // Main scenarios reached
  c_drop: cover property (pkt_dropped);
  c_ferr: cover property (frame_err);
  c_take: cover property (rad_tx_valid && rad_tx_ready);
endmodule
bind spb_top spb_chk u_spb_chk (
  .ref_clk(ref_clk),
  .arst_n(arst_n),
  .cts_flow_en(cts_flow_en),
  .rts_flow_en(rts_flow_en),
  .rts_n(rts_n),
  .dout(dout),
  .cts_n(cts_n),
  .rf_rx_busy(rf_rx_busy),
  .rf_tx_busy(rf_tx_busy),
  .rad_tx_valid(rad_tx_valid),
  .rad_tx_ready(rad_tx_ready),
  .rad_tx_data(rad_tx_data),
  .rf_in_valid(rf_in_valid),
  .rf_in_first(rf_in_first),
  .pkt_dropped(pkt_dropped),
  .frame_err(frame_err)
);
`default_nettype wire

// ===== verif/spb_host.sv
// Host UART model facing the block's serial pins
`include "spb_defs.svh"
`default_nettype none
module spb_host (
  // Clock
  input wire logic ref_clk,
  // Serial pins
  input wire logic dout,
  input wire logic cts_n,
  output logic din
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BIT = `SPB_TICK_DIV * 16; // Cycles per bit, same settings
  logic [7:0] rx_q[$]; // Bytes seen on dout
  int bad_stop = 0; // Frames seen with a low stop bit
  initial din = 1'b1; // Idle high
  // Send one frame; stop low makes a framing fault
  task automatic send(input logic [7:0] b, input logic stop);
    logic [9:0] f;
    f = {stop, b, 1'b0}; // Start low, LSB first, stop
    while (cts_n) @(posedge ref_clk); // Honour clear-to-send
    for (int i = 0; i < 10; i++) begin
      @(posedge ref_clk);
      din <= f[i];
      repeat (BIT - 1) @(posedge ref_clk);
    end
    @(posedge ref_clk);
    din <= 1'b1; // Back to idle
    repeat (2 * BIT) @(posedge ref_clk);
  endtask
  // Receiver samples each bit mid-way
  initial begin
    logic [7:0] b;
    forever begin
      @(negedge dout);
      repeat (BIT / 2) @(posedge ref_clk);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT) @(posedge ref_clk);
        b[i] = dout; // LSB first
      end
      repeat (BIT) @(posedge ref_clk);
      if (dout !== 1'b1) bad_stop++;
      rx_q.push_back(b);
    end
  end
endmodule
`default_nettype wire

// ===== verif/spb_top_tb.sv
// Testbench for the serial port buffering block
`include "spb_defs.svh"
`default_nettype none
module spb_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BIT = `SPB_TICK_DIV * 16;
  typedef struct packed { logic [7:0] len; logic drop; } spb_row_t;
  // Packets filling the transmit buffer; 120 held leaves exactly 8 free
  spb_row_t rows [5] = '{'{8'h64, 1'b0}, '{8'h28, 1'b1}, '{8'h14, 1'b0}, '{8'h09, 1'b1}, '{8'h08, 1'b0}};
  logic ref_clk = 1'b0;
  logic arst_n, parity_en, parity_odd, cts_flow_en, rts_flow_en, din, dout, cts_n, rts_n;
  logic rf_rx_busy, rf_tx_busy, rad_tx_valid, rad_tx_ready, rf_in_valid, rf_in_first;
  logic [7:0] rad_tx_data, rf_in_len, rf_in_data;
  logic pkt_dropped, frame_err, parity_err, rx_overrun;
  int n_fail = 0, check_count = 0, drop_count = 0, ferr_count = 0, exp_drop = 0, perr_count = 0, ovr_count = 0;
  spb_top u_spb_top (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .parity_en(parity_en),
    .parity_odd(parity_odd),
    .cts_flow_en(cts_flow_en),
    .rts_flow_en(rts_flow_en),
    .din(din),
    .dout(dout),
    .cts_n(cts_n),
    .rts_n(rts_n),
    .rf_rx_busy(rf_rx_busy),
    .rf_tx_busy(rf_tx_busy),
    .rad_tx_valid(rad_tx_valid),
    .rad_tx_ready(rad_tx_ready),
    .rad_tx_data(rad_tx_data),
    .rf_in_valid(rf_in_valid),
    .rf_in_first(rf_in_first),
    .rf_in_len(rf_in_len),
    .rf_in_data(rf_in_data),
    .pkt_dropped(pkt_dropped),
    .frame_err(frame_err),
    .parity_err(parity_err),
    .rx_overrun(rx_overrun)
  );
  spb_host u_spb_host (
    .ref_clk(ref_clk),
    .dout(dout),
    .cts_n(cts_n),
    .din(din)
  );
  always #2.5 ref_clk = ~ref_clk;
  // Count event pulses
  always @(posedge ref_clk) begin
    if (pkt_dropped === 1'b1) drop_count++;
    if (frame_err === 1'b1) ferr_count++;
    if (parity_err === 1'b1) perr_count++;
    if (rx_overrun === 1'b1) ovr_count++;
  end
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop;
    if (n_fail == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // One radio packet, one byte per cycle
  task automatic send_pkt(input logic [7:0] len);
    for (int i = 0; i < len; i++) begin
      @(posedge ref_clk);
      rf_in_valid <= 1'b1;
      rf_in_first <= (i == 0);
      rf_in_len <= len;
      rf_in_data <= i[7:0] ^ 8'hA5;
    end
    @(posedge ref_clk);
    rf_in_valid <= 1'b0;
  endtask
  initial begin
    // About six bit times more than the longest path needs
    repeat (42 * BIT) @(posedge ref_clk);
    n_fail++;
    report_and_stop;
  end
  initial begin
    {arst_n, parity_en, parity_odd, cts_flow_en, rts_flow_en, rts_n} = 6'h03;
    {rf_rx_busy, rf_tx_busy, rad_tx_ready, rf_in_valid, rf_in_first} = 5'h10;
    rf_in_len = 8'h00;
    rf_in_data = 8'h00;
    repeat (16) @(posedge ref_clk);
    arst_n <= 1'b1;
    @(posedge ref_clk);
    #1 check("dout idle", {7'h00, dout}, 8'h01);
    foreach (rows[r]) begin
      send_pkt(rows[r].len);
      exp_drop += rows[r].drop;
      repeat (4) @(posedge ref_clk);
      check("drops", drop_count[7:0], exp_drop[7:0]);
    end
    cts_flow_en <= 1'b1;
    fork
      begin
        u_spb_host.send(8'hC3, 1'b0);
        u_spb_host.send(8'h3C, 1'b1);
      end
      begin
        repeat (12 * BIT) @(posedge ref_clk);
        check("held bytes", 8'(u_spb_host.rx_q.size()), 8'h00);
        rts_n <= 1'b0;
        while (u_spb_host.rx_q.size() == 0) @(posedge ref_clk);
        check("dout byte", u_spb_host.rx_q[0], 8'hA5);
        check("dout stop", 8'(u_spb_host.bad_stop), 8'h00);
      end
    join
    // Host stop bit fills the parity slot: even parity of 3C wants 0, so the byte is refused
    parity_en <= 1'b1;
    u_spb_host.send(8'h3C, 1'b1);
    parity_en <= 1'b0;
    #1;
    check("frame errors", ferr_count[7:0], 8'h01);
    check("parity errors", perr_count[7:0], 8'h01);
    check("overruns", ovr_count[7:0], 8'h00);
    check("cts", {7'h00, cts_n}, 8'h00);
    check("valid rx busy", {7'h00, rad_tx_valid}, 8'h00);
    @(posedge ref_clk);
    rf_rx_busy <= 1'b0;
    rf_tx_busy <= 1'b1;
    repeat (4) @(posedge ref_clk);
    #1 check("valid tx busy", {7'h00, rad_tx_valid}, 8'h00);
    @(posedge ref_clk);
    rf_tx_busy <= 1'b0;
    repeat (8) @(posedge ref_clk);
    #1 check("valid", {7'h00, rad_tx_valid}, 8'h01);
    check("radio byte", rad_tx_data, 8'h3C);
    @(posedge ref_clk);
    rad_tx_ready <= 1'b1;
    @(posedge ref_clk);
    rad_tx_ready <= 1'b0;
    repeat (4) @(posedge ref_clk);
    #1 check("empty", {7'h00, rad_tx_valid}, 8'h00);
    report_and_stop;
  end
endmodule
`default_nettype wire
